// File: psync_top.sv
// bus-domain ahb-lite slave and shared synchronizer control
`timescale 1ns/1ps
`default_nettype none
module psync_top #(
    parameter int DATA_W = 32
) (
    // bus clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core clock and reset
    input wire logic core_clk,
    input wire logic core_rst_n,
    // ahb-lite slave port
    input wire psync_pkg::psync_ahb_req_t ahb_req,
    output psync_pkg::psync_ahb_rsp_t ahb_rsp,
    // status seen by the rest of the chip
    output logic sync_busy,
    // core-domain state
    output logic core_enable,
    output logic [DATA_W-1:0] core_count
);
    import psync_pkg::*;

    typedef enum {
        ENG_IDLE,
        ENG_WR,
        ENG_RDREQ,
        ENG_RD_STALL,
        ENG_CONT
    } psync_eng_t;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    psync_eng_t eng_q;
    psync_eng_t eng_d;
    psync_xfer_t xfer_q;
    logic req_tgl_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic hresp_q;
    logic sync_busy_q;
    logic dp_q;
    logic dp_wr_q;
    psync_reg_t dp_reg_q;
    logic cont_q;
    logic rd_valid_q;
    logic [DATA_W-1:0] rd_val_q;
    logic [PSYNC_RDREQ_OFF_W-1:0] rdreq_off_q;
    logic ctrl_en_q;
    logic [31:0] scratch_q;
    logic [DATA_W-1:0] cfg_shadow_q;
    logic ack_tgl;
    logic ack_late;
    logic ack_last;
    logic ack_evt;
    logic [DATA_W-1:0] cap_data;
    logic accept;
    logic dp_active;
    logic eng_busy;
    logic wr_core;
    logic wr_bus;
    logic rd_cnt_stall;
    logic rd_cfg_stall;
    logic en_sync;
    logic rq_go;
    logic start_wr;
    logic wr_launch;
    logic start_rd;
    logic start_cont;
    logic finish_rd;
    logic finish_other;
    logic finish;
    logic launch;
    psync_op_t launch_op;
    logic [31:0] rd_mux;

    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("psync_top data width must be 1 to 32");
    end

    // address decode shared by the data-phase logic
    function automatic psync_reg_t decode(input logic [31:0] addr);
        case (addr)
            {24'h00_0000, PSYNC_OFF_CTRL}: decode = PSYNC_REG_CTRL;
            {24'h00_0000, PSYNC_OFF_STATUS}: decode = PSYNC_REG_STATUS;
            {24'h00_0000, PSYNC_OFF_RDREQ}: decode = PSYNC_REG_RDREQ;
            {24'h00_0000, PSYNC_OFF_SCRATCH}: decode = PSYNC_REG_SCRATCH;
            {24'h00_0000, PSYNC_OFF_CFG}: decode = PSYNC_REG_CFG;
            {24'h00_0000, PSYNC_OFF_CNT}: decode = PSYNC_REG_CNT;
            default: decode = PSYNC_REG_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // core domain and return crossing

    // core registers on their own clock
    psync_core #(
        .DATA_W(DATA_W)
    ) u_core (
        .core_clk(core_clk),
        .core_rst_n(core_rst_n),
        .req_tgl(req_tgl_q),
        .xfer(xfer_q),
        .ack_tgl(ack_tgl),
        .cap_data(cap_data),
        .core_enable(core_enable),
        .core_count(core_count)
    );

    // acknowledge toggle into the bus domain
    psync_sync #(
        .STAGES(PSYNC_SYNC_STAGES)
    ) u_ack_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(ack_tgl),
        .q_late(ack_late),
        .q_last(ack_last)
    );

    assign ack_evt = ack_late ^ ack_last;

    ////////////////////////////////////////////////////////////////////////
    // data-phase decisions

    // classify the pending access against the engine state
    always_comb begin
        accept = ahb_req.hsel & ahb_req.htrans[PSYNC_HTRANS_ACTIVE_BIT] &
            hreadyout_q;
        dp_active = dp_q & ~hreadyout_q;
        eng_busy = (eng_q != ENG_IDLE);
        en_sync = eng_busy & (xfer_q.op == PSYNC_OP_EN);
        wr_core = dp_wr_q & ((dp_reg_q == PSYNC_REG_CTRL) |
            (dp_reg_q == PSYNC_REG_CFG) | (dp_reg_q == PSYNC_REG_RDREQ));
        wr_bus = dp_wr_q & (dp_reg_q == PSYNC_REG_SCRATCH);
        rd_cnt_stall = ~dp_wr_q & (dp_reg_q == PSYNC_REG_CNT) &
            ~rd_valid_q;
        rd_cfg_stall = ~dp_wr_q & (dp_reg_q == PSYNC_REG_CFG) &
            (eng_q == ENG_WR) & (xfer_q.op == PSYNC_OP_CFG);
        rq_go = (ahb_req.hwdata[PSYNC_RDREQ_REQ_BIT] |
            ahb_req.hwdata[PSYNC_RDREQ_CONT_BIT]) &
            (ahb_req.hwdata[PSYNC_RDREQ_OFF_LSB +: PSYNC_RDREQ_OFF_W] ==
            PSYNC_OFF_CNT);
        start_wr = dp_active & wr_core & ~eng_busy;
        wr_launch = start_wr & ((dp_reg_q != PSYNC_REG_RDREQ) | rq_go);
        start_rd = dp_active & rd_cnt_stall & ~eng_busy;
        finish_rd = (eng_q == ENG_RD_STALL) & ack_evt;
        finish_other = dp_active & ~wr_core & ~rd_cnt_stall &
            ~rd_cfg_stall & ~(wr_bus & en_sync);
        finish = start_wr | finish_rd | finish_other;
        start_cont = cont_q & ~eng_busy & ~(dp_active &
            (wr_core | rd_cnt_stall));
        launch = wr_launch | start_rd | start_cont;
        launch_op = PSYNC_OP_RD;
        if (wr_launch && dp_reg_q == PSYNC_REG_CTRL) begin
            launch_op = PSYNC_OP_EN;
        end else if (wr_launch && dp_reg_q == PSYNC_REG_CFG) begin
            launch_op = PSYNC_OP_CFG;
        end
    end

    // read data multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (dp_reg_q)
            PSYNC_REG_CTRL: rd_mux[PSYNC_CTRL_EN_BIT] = ctrl_en_q;
            PSYNC_REG_STATUS: rd_mux[PSYNC_STATUS_BUSY_BIT] = sync_busy_q;
            PSYNC_REG_RDREQ: begin
                rd_mux[PSYNC_RDREQ_OFF_LSB +: PSYNC_RDREQ_OFF_W] = rdreq_off_q;
                rd_mux[PSYNC_RDREQ_CONT_BIT] = cont_q;
            end
            PSYNC_REG_SCRATCH: rd_mux = scratch_q;
            PSYNC_REG_CFG: rd_mux[DATA_W-1:0] = cfg_shadow_q;
            PSYNC_REG_CNT: begin
                if (finish_rd) begin
                    rd_mux[DATA_W-1:0] = cap_data;
                end else begin
                    rd_mux[DATA_W-1:0] = rd_val_q;
                end
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    // address phase capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_q <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_reg_q <= PSYNC_REG_NONE;
        end else if (accept) begin
            dp_q <= 1'b1;
            dp_wr_q <= ahb_req.hwrite;
            dp_reg_q <= decode(ahb_req.haddr);
        end else if (finish) begin
            dp_q <= 1'b0;
        end
    end

    // one wait state per access, more while stalled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            if (accept) begin
                hreadyout_q <= 1'b0;
            end else if (finish) begin
                hreadyout_q <= 1'b1;
                hrdata_q <= dp_wr_q ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign ahb_rsp.hreadyout = hreadyout_q;
    assign ahb_rsp.hrdata = hrdata_q;
    assign ahb_rsp.hresp = hresp_q;

    ////////////////////////////////////////////////////////////////////////
    // bus-side register writes

    // shadows that read back without waiting, except CFG while its own write crossing is outstanding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en_q <= 1'b0;
            cfg_shadow_q <= PSYNC_RST_STEP[DATA_W-1:0];
            scratch_q <= PSYNC_RST_WORD;
            rdreq_off_q <= '0;
        end else if (start_wr) begin
            case (dp_reg_q)
                PSYNC_REG_CTRL:
                    ctrl_en_q <= ahb_req.hwdata[PSYNC_CTRL_EN_BIT];
                PSYNC_REG_CFG: cfg_shadow_q <= ahb_req.hwdata[DATA_W-1:0];
                PSYNC_REG_RDREQ: rdreq_off_q <=
                    ahb_req.hwdata[PSYNC_RDREQ_OFF_LSB +: PSYNC_RDREQ_OFF_W];
                default: ;
            endcase
        end else if (finish_other && wr_bus) begin
            scratch_q <= ahb_req.hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronizer engine

    // engine state: which crossing is outstanding
    always_comb begin
        eng_d = eng_q;
        case (eng_q)
            ENG_IDLE: begin
                if (wr_launch && dp_reg_q == PSYNC_REG_RDREQ) begin
                    eng_d = ENG_RDREQ;
                end else if (wr_launch) begin
                    eng_d = ENG_WR;
                end else if (start_rd) begin
                    eng_d = ENG_RD_STALL;
                end else if (start_cont) begin
                    eng_d = ENG_CONT;
                end
            end
            ENG_WR, ENG_RDREQ, ENG_RD_STALL, ENG_CONT: begin
                if (ack_evt) begin
                    eng_d = ENG_IDLE;
                end
            end
            default: eng_d = ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eng_q <= ENG_IDLE;
        end else begin
            eng_q <= eng_d;
        end
    end

    // payload and request toggle, held until the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl_q <= 1'b0;
            xfer_q <= '{op: PSYNC_OP_RD, wdata: PSYNC_RST_WORD};
        end else if (launch) begin
            req_tgl_q <= ~req_tgl_q;
            xfer_q <= '{op: launch_op, wdata: ahb_req.hwdata};
        end
    end

    // busy flag: shown for writes and first capture only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_busy_q <= 1'b0;
        end else if (wr_launch) begin
            sync_busy_q <= 1'b1;
        end else if (ack_evt) begin
            sync_busy_q <= 1'b0;
        end
    end

    assign sync_busy = sync_busy_q;

    // continuous mode: set by its request, cancelled by any other
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cont_q <= 1'b0;
        end else if (start_wr) begin
            cont_q <= (dp_reg_q == PSYNC_REG_RDREQ) & rq_go &
                ahb_req.hwdata[PSYNC_RDREQ_CONT_BIT];
        end else if (start_rd) begin
            cont_q <= 1'b0;
        end
    end

    // captured value for unstalled reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_val_q <= PSYNC_RST_WORD[DATA_W-1:0];
        end else if (ack_evt && (eng_q == ENG_RDREQ || eng_q == ENG_CONT)) begin
            rd_valid_q <= 1'b1;
            rd_val_q <= cap_data;
        end else if (wr_launch && dp_reg_q == PSYNC_REG_RDREQ) begin
            rd_valid_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: psync_pkg.sv
// shared constants, types and register map of the peripheral synchronizer
package psync_pkg;

    // register byte offsets
    localparam logic [7:0] PSYNC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PSYNC_OFF_STATUS = 8'h04;
    localparam logic [7:0] PSYNC_OFF_RDREQ = 8'h08;
    localparam logic [7:0] PSYNC_OFF_SCRATCH = 8'h0C;
    localparam logic [7:0] PSYNC_OFF_CFG = 8'h10;
    localparam logic [7:0] PSYNC_OFF_CNT = 8'h14;

    // field positions
    localparam int PSYNC_CTRL_EN_BIT = 0;
    localparam int PSYNC_STATUS_BUSY_BIT = 0;
    localparam int PSYNC_RDREQ_OFF_LSB = 0;
    localparam int PSYNC_RDREQ_OFF_W = 8;
    localparam int PSYNC_RDREQ_CONT_BIT = 14;
    localparam int PSYNC_RDREQ_REQ_BIT = 15;

    // values after reset
    localparam logic [31:0] PSYNC_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] PSYNC_RST_STEP = 32'h0000_0001;

    // synchronizer depth
    localparam int PSYNC_SYNC_STAGES = 3;

    // core cycles the answer is held back, to stretch a crossing
    localparam int PSYNC_CORE_HOLD = 3;

    // ahb transfer type bit that marks an active transfer
    localparam int PSYNC_HTRANS_ACTIVE_BIT = 1;

    // operations carried across to the core domain
    typedef enum logic [1:0] {
        PSYNC_OP_EN,
        PSYNC_OP_CFG,
        PSYNC_OP_RD
    } psync_op_t;

    // decoded register
    typedef enum logic [2:0] {
        PSYNC_REG_CTRL,
        PSYNC_REG_STATUS,
        PSYNC_REG_RDREQ,
        PSYNC_REG_SCRATCH,
        PSYNC_REG_CFG,
        PSYNC_REG_CNT,
        PSYNC_REG_NONE
    } psync_reg_t;

    // ahb-lite slave request side
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } psync_ahb_req_t;

    // ahb-lite slave response side
    typedef struct packed {
        logic hreadyout;
        logic [31:0] hrdata;
        logic hresp;
    } psync_ahb_rsp_t;

    // payload held stable while a crossing is outstanding
    typedef struct packed {
        psync_op_t op;
        logic [31:0] wdata;
    } psync_xfer_t;

endpackage

// File: psync_sync.sv
// multi-stage synchronizer for a single level or toggle
`timescale 1ns/1ps
`default_nettype none
module psync_sync #(
    parameter int STAGES = 3
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst_n,
    // level from the other domain
    input wire logic d,
    // last two stages, compared by the user
    output logic q_late,
    output logic q_last
);
    import psync_pkg::*;

    logic [STAGES-1:0] stage_q;

    // refuse depths that cannot give two settled stages
    if (STAGES < 3) begin : g_bad_depth
        $error("psync_sync needs at least three stages");
    end

    // first stage, read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q[0] <= 1'b0;
        end else begin
            stage_q[0] <= d;
        end
    end

    // remaining stages
    for (genvar i = 1; i < STAGES; i++) begin : g_stage
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                stage_q[i] <= 1'b0;
            end else begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign q_late = stage_q[STAGES-2];
    assign q_last = stage_q[STAGES-1];
endmodule
`default_nettype wire

// File: psync_core.sv
// core-domain side of the synchronizer: core registers and counter
`timescale 1ns/1ps
`default_nettype none
module psync_core #(
    parameter int DATA_W = 32
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic core_rst_n,
    // crossing from the bus domain
    input wire logic req_tgl,
    input wire psync_pkg::psync_xfer_t xfer,
    // crossing back to the bus domain
    output logic ack_tgl,
    output logic [DATA_W-1:0] cap_data,
    // core state
    output logic core_enable,
    output logic [DATA_W-1:0] core_count
);
    import psync_pkg::*;

    logic req_late;
    logic req_last;
    logic req_evt;
    logic [DATA_W-1:0] step_q;
    logic [PSYNC_CORE_HOLD-1:0] evt_dly_q;

    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("psync_core data width must be 1 to 32");
    end

    // request toggle into the core domain
    psync_sync #(
        .STAGES(PSYNC_SYNC_STAGES)
    ) u_req_sync (
        .clk(core_clk),
        .rst_n(core_rst_n),
        .d(req_tgl),
        .q_late(req_late),
        .q_last(req_last)
    );

    assign req_evt = req_late ^ req_last;

    // write-synchronized core registers
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            core_enable <= 1'b0;
            step_q <= PSYNC_RST_STEP[DATA_W-1:0];
        end else if (req_evt) begin
            case (xfer.op)
                PSYNC_OP_EN: core_enable <= xfer.wdata[PSYNC_CTRL_EN_BIT];
                PSYNC_OP_CFG: step_q <= xfer.wdata[DATA_W-1:0];
                default: ;
            endcase
        end
    end

    // running counter, the read-synchronized value
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            core_count <= PSYNC_RST_WORD[DATA_W-1:0];
        end else if (core_enable) begin
            core_count <= core_count + step_q;
        end
    end

    // delay line so every crossing spans five to six core periods
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            evt_dly_q <= '0;
        end else begin
            evt_dly_q <= {evt_dly_q[PSYNC_CORE_HOLD-2:0], req_evt};
        end
    end

    // capture for reads and answer every request
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cap_data <= PSYNC_RST_WORD[DATA_W-1:0];
            ack_tgl <= 1'b0;
        end else begin
            if (req_evt && xfer.op == PSYNC_OP_RD) begin
                cap_data <= core_count;
            end
            if (evt_dly_q[PSYNC_CORE_HOLD-1]) begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end
endmodule
`default_nettype wire

// File: psync_properties.sv
// concurrent checks on the synchronizer's top-level ports
`timescale 1ns/1ps
`default_nettype none
module psync_properties #(
    parameter int DATA_W = 32
) (
    // bus clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core clock and reset
    input wire logic core_clk,
    input wire logic core_rst_n,
    // ahb-lite slave port
    input wire psync_pkg::psync_ahb_req_t ahb_req,
    input wire psync_pkg::psync_ahb_rsp_t ahb_rsp,
    // status and core state
    input wire logic sync_busy,
    input wire logic core_enable,
    input wire logic [DATA_W-1:0] core_count
);
    import psync_pkg::*;
    logic pg;
    logic [7:0] a;
    logic [7:0] busy_cnt_q;
    logic [7:0] stall_cnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    //////////////////////////////////////////////////
    // transfer taken at this edge inside the page
    assign pg = ahb_req.hsel & ahb_req.htrans[1] & ahb_rsp.hreadyout
        & (ahb_req.haddr[31:8] == 24'h000000);
    assign a = ahb_req.haddr[7:0];
    // length of the current busy spell
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_q <= 8'h00;
        end else begin
            busy_cnt_q <= sync_busy ? busy_cnt_q + 8'h01 : 8'h00;
        end
    end
    // length of the current bus stall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_cnt_q <= 8'h00;
        end else begin
            stall_cnt_q <= ahb_rsp.hreadyout ? 8'h00 : stall_cnt_q + 8'h01;
        end
    end
    // plain access: one wait state, then done
    sequence s_one_wait;
        !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
    endsequence
    //////////////////////////////////////////////////
    a_resp_okay: assert property (!ahb_rsp.hresp)
        else $error("error response seen");
    a_reset_idle: assert property ($rose(rst_n) |-> !sync_busy)
        else $error("busy right after reset");
    a_free_read: assert property (pg && !ahb_req.hwrite
        && (a == PSYNC_OFF_SCRATCH || a == PSYNC_OFF_STATUS) |=> s_one_wait)
        else $error("bus-side read stalled");
    a_ctrl_read: assert property (pg && !ahb_req.hwrite
        && a == PSYNC_OFF_CTRL |=> s_one_wait)
        else $error("enable read stalled");
    a_write_busy: assert property (pg && ahb_req.hwrite
        && a == PSYNC_OFF_CTRL |=> ##[1:100] (ahb_rsp.hreadyout && sync_busy))
        else $error("enable write without busy");
    a_busy_min: assert property ($rose(sync_busy) |-> sync_busy[*6])
        else $error("crossing too short");
    // busy spell in bus cycles for the bench's 10 ns core clock
    a_sync_span: assert property ($fell(sync_busy)
        |-> busy_cnt_q >= 8'h0F && busy_cnt_q <= 8'h12)
        else $error("crossing outside delay window");
    a_busy_bound: assert property (busy_cnt_q < 8'h50)
        else $error("busy stuck");
    a_stall_bound: assert property (stall_cnt_q < 8'h60)
        else $error("bus stall stuck");
    a_rdata_hold: assert property (!ahb_rsp.hreadyout
        |-> $stable(ahb_rsp.hrdata))
        else $error("read data moved during stall");
    a_cnt_quiet: assert property (pg && !ahb_req.hwrite
        && a == PSYNC_OFF_CNT && !sync_busy
        |=> !sync_busy until ahb_rsp.hreadyout)
        else $error("synced read raised busy");
    a_count_off: assert property (@(posedge core_clk)
        disable iff (!core_rst_n) !core_enable |=> $stable(core_count))
        else $error("counter moved while disabled");
endmodule
bind psync_top psync_properties #(.DATA_W(DATA_W)) u_props (.clk(clk),
    .rst_n(rst_n), .core_clk(core_clk), .core_rst_n(core_rst_n),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .sync_busy(sync_busy),
    .core_enable(core_enable), .core_count(core_count));
`default_nettype wire

// File: psync_master.sv
// ahb-lite bus master model for single word transfers
`timescale 1ns/1ps
`default_nettype none
module psync_master (
    // bus clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // master side of the bus
    output var psync_pkg::psync_ahb_req_t req,
    input wire psync_pkg::psync_ahb_rsp_t rsp
);
    import psync_pkg::*;
    initial req = '0;
    // one transfer; waits counts edges of the data phase
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output int waits);
        waits = 0;
        req.hsel <= 1'b1;
        req.haddr <= {24'h000000, a};
        req.htrans <= 2'h2;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= wr ? wd : ~req.hwdata;
        do begin
            @(posedge clk);
            waits++;
        end while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask
endmodule
`default_nettype wire

// File: psync_top_tb.sv
// self-checking bench of the peripheral synchronizer
`timescale 1ns/1ps
`default_nettype none
module psync_top_tb;
    import psync_pkg::*;
    logic clk;
    logic rst_n;
    logic core_clk;
    logic core_run;
    psync_ahb_req_t req;
    psync_ahb_rsp_t rsp;
    logic busy;
    logic en;
    logic [31:0] cnt;
    logic [31:0] d;
    logic [31:0] d0;
    int w;
    int ws;
    int miscompares;
    int comparisons;
    psync_top #(.DATA_W(32)) DUT (.clk(clk), .rst_n(rst_n),
        .core_clk(core_clk), .core_rst_n(rst_n), .ahb_req(req),
        .ahb_rsp(rsp), .sync_busy(busy), .core_enable(en),
        .core_count(cnt));
    psync_master M (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));
    //////////////////////////////////////////////////
    // bus clock, then core clock that may stop
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        core_clk = 1'b0;
        #1.3;
        forever #5 core_clk = ~core_clk & core_run;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        M.xfer(1'b1, a, v, d, w);
    endtask
    task automatic rd(input logic [7:0] a);
        M.xfer(1'b0, a, 32'h0, d, w);
    endtask
    // poll the busy flag until clear
    task automatic idle;
        do rd(PSYNC_OFF_STATUS); while (d[0] !== 1'b0);
    endtask
    // two counter reads apart in time
    task automatic cnt2;
        rd(PSYNC_OFF_CNT);
        d0 = d;
        repeat (20) @(posedge clk);
        rd(PSYNC_OFF_CNT);
    endtask
    //////////////////////////////////////////////////
    task automatic t_plain;
        rd(PSYNC_OFF_STATUS);
        chk(d, 32'h0);
        chk(cnt, 32'h0);
        wr(PSYNC_OFF_SCRATCH, 32'hA5C35A3C);
        rd(PSYNC_OFF_SCRATCH);
        chk(d, 32'hA5C35A3C);
        chk(32'(w), 32'h2);
        rd(8'h40);
        chk(d, 32'h0);
    endtask
    task automatic t_enable;
        wr(PSYNC_OFF_CTRL, 32'h1);
        rd(PSYNC_OFF_CTRL);
        chk(d, 32'h1);
        chk({31'h0, en}, 32'h0);
        wr(PSYNC_OFF_SCRATCH, 32'h0);
        chk(32'(w > 2), 32'h1);
        rd(PSYNC_OFF_STATUS);
        chk(d, 32'h0);
        chk({31'h0, en}, 32'h1);
    endtask
    task automatic t_cfg;
        wr(PSYNC_OFF_CFG, 32'h3);
        rd(PSYNC_OFF_CTRL);
        chk(32'(w), 32'h2);
        wr(PSYNC_OFF_CFG, 32'h4);
        chk(32'(w > 2), 32'h1);
        rd(PSYNC_OFF_CFG);
        chk(d, 32'h4);
        chk(32'(w > 2), 32'h1);
        idle();
        rd(PSYNC_OFF_CNT);
        chk(32'(w > 5), 32'h1);
        ws = w;
        d0 = d;
        wr(PSYNC_OFF_CFG, 32'h1);
        rd(PSYNC_OFF_CNT);
        chk(32'(w > ws), 32'h1);
        chk(32'(d > d0), 32'h1);
    endtask
    task automatic t_req;
        wr(PSYNC_OFF_RDREQ, 32'h8000 | 32'(PSYNC_OFF_CNT));
        chk({31'h0, busy}, 32'h1);
        rd(PSYNC_OFF_STATUS);
        chk(d, 32'h1);
        idle();
        cnt2();
        chk(d, d0);
        chk(32'(w), 32'h2);
        wr(PSYNC_OFF_RDREQ, 32'hC000 | 32'(PSYNC_OFF_CNT));
        idle();
        cnt2();
        chk(32'(d > d0), 32'h1);
        chk(32'(w), 32'h2);
        rd(PSYNC_OFF_STATUS);
        chk(d, 32'h0);
        core_run <= 1'b0;
        repeat (10) @(posedge clk);
        cnt2();
        chk(d, d0);
        core_run <= 1'b1;
        wr(PSYNC_OFF_RDREQ, 32'hC000 | 32'(PSYNC_OFF_CNT));
        idle();
        wr(PSYNC_OFF_CFG, 32'h2);
        idle();
        cnt2();
        chk(d, d0);
    endtask
    //////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        miscompares = 0;
        comparisons = 0;
        core_run = 1'b1;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_plain();
        t_enable();
        t_cfg();
        t_req();
        tally_and_finish();
    end
    // watchdog against a hung stall
    initial begin
        #40000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
